/* design/rxc_defines.vh */
// register map, field positions, reset values and timing counts of the receiver configuration
`ifndef RXC_DEFINES_VH
`define RXC_DEFINES_VH

`define RXC_ADDR_W 6
`define RXC_ADDR_CHANNEL_FILTER 6'h0a
`define RXC_ADDR_GAIN_CTRL 6'h0b
`define RXC_ADDR_FIRST_STAGE 6'h0c

`define RXC_RST_CHANNEL_FILTER 8'h00
`define RXC_RST_GAIN_CTRL 8'h1a
`define RXC_RST_FIRST_STAGE 8'hd8

// channel/filter register fields
`define RXC_F_RX_CHANNEL_SELECT 7
`define RXC_F_AM_MIXER 6
`define RXC_F_LP_HI 5
`define RXC_F_LP_LO 3
`define RXC_F_ZERO_HI 2
`define RXC_F_ZERO_LO 0

// gain control register fields
`define RXC_F_LOW_POWER 7
`define RXC_F_LF_SPLIT 6
`define RXC_F_LOWFREQ_INPUT_ENABLE 5
`define RXC_F_AGC_EN 4
`define RXC_F_AGC_FULL 3
`define RXC_F_AGC_ALG 2
`define RXC_F_SQ_DYN 1
`define RXC_F_PMIX_CLK 0

// first stage gain register fields
`define RXC_F_AM_GAIN_HI 7
`define RXC_F_AM_GAIN_LO 5
`define RXC_F_PM_GAIN_HI 4
`define RXC_F_PM_GAIN_LO 2
`define RXC_F_CLIP 1
`define RXC_F_FORCED 0

// timing
`define RXC_CLK_MHZ 20
`define RXC_SQ_START_US_X100 1888
`define RXC_SQ_START_CYC ((`RXC_SQ_START_US_X100 * `RXC_CLK_MHZ + 99) / 100)
`define RXC_MRT_STEP_FC 64
`define RXC_MRT_MIN_STEPS 4

`endif

/* design/rxc_receiver_config_regs.v */
// receiver configuration registers with squelch timing and derived receive-chain controls
`default_nettype none
`include "rxc_defines.vh"

// Functional notes
// R1: single channel enabled: select bit chooses AM/PM
// R2: dual channels, manual mode: select bit picks framing
// R3: demodulator bit: 0 peak, 1 mixer
// R4: very high bitrate presets demodulator to mixer
// R5: lowpass and zero codes reset 0, drive filter
// R6: low power bit sets receiver low power
// R7: LF split bit routes inputs to AM/PM
// R8: LF enable routes low frequency to input
// R9: gain control enable and scope, default one
// R10: gain algorithm: 0 preset, 1 reset start
// R11: host should prefer preset algorithm, short SOF
// R12: dynamic squelch starts 18.88us after transmit ends
// R13: mixer clock: driver or internal; single-ended internal
// R14: three-bit first stage gain codes per channel
// R15: clip bit clips stages; preset in peer mode
// R16: forced gain bit overrides stage two/three gain
// R17: host restarts receiver after clearing forced gain
// R18: defaults 00, 1a, d8 at reset/set-default
// R19: mask timer steps 64 carrier periods after transmit
module rxc_receiver_config_regs
(
   input wire CLK,
   input wire RESET,
   input wire SET_DEFAULT,
   input wire REG_WR,
   input wire [`RXC_ADDR_W-1:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   output reg [7:0] REG_RDATA,
   input wire RX_ENABLE,
   input wire RX_DUAL_CHANNEL,
   input wire MANUAL_CH_SELECT,
   input wire AUTO_FRAMING_PM,
   input wire VERY_HIGH_BITRATE,
   input wire PEER_ACTIVE_PRESET,
   input wire SINGLE_ENDED,
   input wire TX_END,
   input wire [7:0] MASK_RX_STEPS,
   input wire CARRIER_CLK_IN,
   output reg AM_CH_EN,
   output reg PM_CH_EN,
   output reg FRAMING_USES_PM,
   output reg AM_DEMOD_MIXER,
   output reg [2:0] LOWPASS_CODE,
   output reg [2:0] ZERO_SETTING,
   output reg RECEIVER_LOW_POWER,
   output reg LOWFREQ_INPUT_SPLIT,
   output reg LOWFREQ_INPUT_ENABLE,
   output reg AGC_ENABLE,
   output reg AGC_FULL_PERIOD,
   output reg AGC_ALG_RESET,
   output reg SQUELCH_ACTIVE,
   output reg MASK_RX_ACTIVE,
   output reg PM_MIXER_INTERNAL,
   output reg [2:0] AM_STAGE1_GAIN,
   output reg [2:0] PM_STAGE1_GAIN,
   output reg STAGE_CLIP,
   output reg FORCED_PEER_GAIN
);

   reg [7:0] channel_filter_cfg;
   reg [7:0] gain_ctrl_cfg;
   reg [7:0] first_stage_gain;
   reg very_high_bitrate_prev;
   reg peer_prev;
   reg fc_meta;
   reg fc_sync;
   reg fc_prev;
   reg [8:0] sq_delay;
   reg sq_wait;
   reg [5:0] fc_count;
   reg [7:0] step_count;
   reg [7:0] step_limit;
   reg next_squelch;
   wire fc_edge;
   wire very_high_bitrate_rise;
   wire peer_rise;
   wire [7:0] mrt_steps;
   wire fc_wrap;
   wire mask_done;
   wire sq_start;
   wire wr_channel_filter;
   wire wr_gain_ctrl;
   wire wr_first_stage;

   localparam [31:0] fc_last = `RXC_MRT_STEP_FC - 1;
   localparam [31:0] sq_last = `RXC_SQ_START_CYC - 1;

   // write strobes per register
   assign wr_channel_filter = REG_WR && REG_ADDR == `RXC_ADDR_CHANNEL_FILTER;
   assign wr_gain_ctrl = REG_WR && REG_ADDR == `RXC_ADDR_GAIN_CTRL;
   assign wr_first_stage = REG_WR && REG_ADDR == `RXC_ADDR_FIRST_STAGE;
   assign fc_edge = fc_sync & ~fc_prev;
   assign very_high_bitrate_rise = VERY_HIGH_BITRATE & ~very_high_bitrate_prev;
   assign peer_rise = PEER_ACTIVE_PRESET & ~peer_prev;
   // R19
   assign mrt_steps = (MASK_RX_STEPS < 8'd`RXC_MRT_MIN_STEPS) ?
      8'd`RXC_MRT_MIN_STEPS : MASK_RX_STEPS;
   // last carrier edge of a mask step, and of the last step
   assign fc_wrap = MASK_RX_ACTIVE && fc_edge && fc_count == fc_last[5:0];
   assign mask_done = fc_wrap && step_count == step_limit - 8'd1; // R19
   assign sq_start = sq_wait && sq_delay == sq_last[8:0]; // R12

   // register file, set-default wins over a same-cycle write
   always @(posedge CLK)
   begin
      if (RESET || SET_DEFAULT)
      begin
         channel_filter_cfg <= `RXC_RST_CHANNEL_FILTER; // R18
      end
      else if (wr_channel_filter)
      begin
         channel_filter_cfg <= REG_WDATA;
      end
      else if (very_high_bitrate_rise)
      begin
         channel_filter_cfg[`RXC_F_AM_MIXER] <= 1'b1; // R4
      end
   end

   always @(posedge CLK)
   begin
      if (RESET || SET_DEFAULT)
      begin
         gain_ctrl_cfg <= `RXC_RST_GAIN_CTRL; // R18
      end
      else if (wr_gain_ctrl)
      begin
         gain_ctrl_cfg <= REG_WDATA;
      end
   end

   // a write wins over a same-cycle peer preset edge
   always @(posedge CLK)
   begin
      if (RESET || SET_DEFAULT)
      begin
         first_stage_gain <= `RXC_RST_FIRST_STAGE; // R18
      end
      else if (wr_first_stage)
      begin
         first_stage_gain <= REG_WDATA;
      end
      else if (peer_rise)
      begin
         first_stage_gain[`RXC_F_CLIP] <= 1'b1; // R15
         first_stage_gain[`RXC_F_FORCED] <= 1'b1; // R16
      end
   end

   // read port, unmapped addresses read zero
   always @(posedge CLK)
   begin
      if (RESET)
      begin
         REG_RDATA <= 8'h00;
      end
      else if (REG_ADDR == `RXC_ADDR_CHANNEL_FILTER)
      begin
         REG_RDATA <= channel_filter_cfg;
      end
      else if (REG_ADDR == `RXC_ADDR_GAIN_CTRL)
      begin
         REG_RDATA <= gain_ctrl_cfg;
      end
      else if (REG_ADDR == `RXC_ADDR_FIRST_STAGE)
      begin
         REG_RDATA <= first_stage_gain;
      end
      else
      begin
         REG_RDATA <= 8'h00;
      end
   end

   // edge history and carrier synchroniser
   always @(posedge CLK)
   begin
      if (RESET)
      begin
         very_high_bitrate_prev <= 1'b0;
         peer_prev <= 1'b0;
         fc_meta <= 1'b0;
         fc_sync <= 1'b0;
         fc_prev <= 1'b0;
      end
      else
      begin
         very_high_bitrate_prev <= VERY_HIGH_BITRATE;
         peer_prev <= PEER_ACTIVE_PRESET;
         fc_meta <= CARRIER_CLK_IN;
         fc_sync <= fc_meta;
         fc_prev <= fc_sync;
      end
   end

   // mask timer after end of transmit
   always @(posedge CLK)
   begin
      if (RESET)
      begin
         MASK_RX_ACTIVE <= 1'b0;
         fc_count <= 6'd0;
         step_count <= 8'd0;
         step_limit <= 8'd0;
      end
      else if (TX_END)
      begin
         MASK_RX_ACTIVE <= 1'b1;
         fc_count <= 6'd0;
         step_count <= 8'd0;
         step_limit <= mrt_steps;
      end
      else if (MASK_RX_ACTIVE && fc_edge)
      begin
         if (fc_wrap)
         begin
            fc_count <= 6'd0;
            step_count <= step_count + 8'd1;
         end
         else
         begin
            fc_count <= fc_count + 6'd1;
         end
         if (mask_done)
         begin
            MASK_RX_ACTIVE <= 1'b0; // R19
         end
      end
   end

   // squelch start delay, armed only with dynamic squelch set
   always @(posedge CLK)
   begin
      if (RESET)
      begin
         sq_wait <= 1'b0;
         sq_delay <= 9'd0;
      end
      else if (TX_END)
      begin
         sq_wait <= gain_ctrl_cfg[`RXC_F_SQ_DYN]; // R12
         sq_delay <= 9'd0;
      end
      else if (sq_wait)
      begin
         if (sq_start)
         begin
            sq_wait <= 1'b0;
         end
         sq_delay <= sq_delay + 9'd1;
      end
   end

   // squelch window output
   always @(posedge CLK)
   begin
      if (RESET || TX_END)
      begin
         SQUELCH_ACTIVE <= 1'b0;
      end
      else
      begin
         SQUELCH_ACTIVE <= next_squelch;
      end
   end

   // expiry clears on the same edge, so squelch never outlives the mask
   always @*
   begin
      next_squelch = SQUELCH_ACTIVE;
      if (sq_start && MASK_RX_ACTIVE)
      begin
         next_squelch = 1'b1; // R12
      end
      if (!MASK_RX_ACTIVE || mask_done)
      begin
         next_squelch = 1'b0; // R12
      end
   end

   // registered receive-chain controls
   always @(posedge CLK)
   begin
      if (RESET)
      begin
         AM_CH_EN <= 1'b0;
         PM_CH_EN <= 1'b0;
         FRAMING_USES_PM <= 1'b0;
         AM_DEMOD_MIXER <= 1'b0;
         LOWPASS_CODE <= 3'd0;
         ZERO_SETTING <= 3'd0;
         RECEIVER_LOW_POWER <= 1'b0;
         LOWFREQ_INPUT_SPLIT <= 1'b0;
         LOWFREQ_INPUT_ENABLE <= 1'b0;
         AGC_ENABLE <= 1'b0;
         AGC_FULL_PERIOD <= 1'b0;
         AGC_ALG_RESET <= 1'b0;
         PM_MIXER_INTERNAL <= 1'b0;
         AM_STAGE1_GAIN <= 3'd0;
         PM_STAGE1_GAIN <= 3'd0;
         STAGE_CLIP <= 1'b0;
         FORCED_PEER_GAIN <= 1'b0;
      end
      else
      begin
         if (!RX_ENABLE)
         begin
            AM_CH_EN <= 1'b0;
            PM_CH_EN <= 1'b0;
            FRAMING_USES_PM <= 1'b0;
         end
         else if (!RX_DUAL_CHANNEL)
         begin
            AM_CH_EN <= ~channel_filter_cfg[`RXC_F_RX_CHANNEL_SELECT]; // R1
            PM_CH_EN <= channel_filter_cfg[`RXC_F_RX_CHANNEL_SELECT]; // R1
            FRAMING_USES_PM <= channel_filter_cfg[`RXC_F_RX_CHANNEL_SELECT];
         end
         else
         begin
            AM_CH_EN <= 1'b1;
            PM_CH_EN <= 1'b1;
            FRAMING_USES_PM <= MANUAL_CH_SELECT ?
               channel_filter_cfg[`RXC_F_RX_CHANNEL_SELECT] : AUTO_FRAMING_PM; // R2
         end
         AM_DEMOD_MIXER <= channel_filter_cfg[`RXC_F_AM_MIXER]; // R3
         LOWPASS_CODE <= channel_filter_cfg[`RXC_F_LP_HI:`RXC_F_LP_LO]; // R5
         ZERO_SETTING <= channel_filter_cfg[`RXC_F_ZERO_HI:`RXC_F_ZERO_LO]; // R5
         RECEIVER_LOW_POWER <= gain_ctrl_cfg[`RXC_F_LOW_POWER]; // R6
         LOWFREQ_INPUT_SPLIT <= gain_ctrl_cfg[`RXC_F_LF_SPLIT]; // R7
         LOWFREQ_INPUT_ENABLE <= gain_ctrl_cfg[`RXC_F_LOWFREQ_INPUT_ENABLE]; // R8
         AGC_ENABLE <= gain_ctrl_cfg[`RXC_F_AGC_EN]; // R9
         AGC_FULL_PERIOD <= gain_ctrl_cfg[`RXC_F_AGC_FULL]; // R9
         AGC_ALG_RESET <= gain_ctrl_cfg[`RXC_F_AGC_ALG]; // R10
         PM_MIXER_INTERNAL <= gain_ctrl_cfg[`RXC_F_PMIX_CLK] | SINGLE_ENDED; // R13
         AM_STAGE1_GAIN <= first_stage_gain[`RXC_F_AM_GAIN_HI:`RXC_F_AM_GAIN_LO]; // R14
         PM_STAGE1_GAIN <= first_stage_gain[`RXC_F_PM_GAIN_HI:`RXC_F_PM_GAIN_LO]; // R14
         STAGE_CLIP <= first_stage_gain[`RXC_F_CLIP]; // R15
         FORCED_PEER_GAIN <= first_stage_gain[`RXC_F_FORCED]; // R16
      end
   end

endmodule
`default_nettype wire

/* bench/rx_config_checker.sv */
// assertions for the receiver configuration register block
`default_nettype none
module rx_config_checker
(
   input wire logic CLK,
   input wire logic RESET,
   input wire logic SET_DEFAULT,
   input wire logic REG_WR,
   input wire logic [5:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic [7:0] REG_RDATA,
   input wire logic RX_ENABLE,
   input wire logic RX_DUAL_CHANNEL,
   input wire logic AM_CH_EN,
   input wire logic PM_CH_EN,
   input wire logic FRAMING_USES_PM,
   input wire logic VERY_HIGH_BITRATE,
   input wire logic AM_DEMOD_MIXER,
   input wire logic SINGLE_ENDED,
   input wire logic PM_MIXER_INTERNAL,
   input wire logic TX_END,
   input wire logic SQUELCH_ACTIVE,
   input wire logic MASK_RX_ACTIVE
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CLK);
   endclocking
   default disable iff (RESET);
   sequence s_lone_wr;
      REG_WR && !SET_DEFAULT && REG_ADDR == 6'h0b ##1 !REG_WR && !SET_DEFAULT && $stable(REG_ADDR);
   endsequence
   sequence s_very_high_bitrate_rise;
      $rose(VERY_HIGH_BITRATE) && !REG_WR && !SET_DEFAULT ##1 !REG_WR && !SET_DEFAULT;
   endsequence
   a_gain_readback: assert property (s_lone_wr |-> ##1 REG_RDATA == $past(REG_WDATA, 2))
      else $error("readback mismatch");
   a_very_high_bitrate_mixer: assert property (s_very_high_bitrate_rise |-> ##1 AM_DEMOD_MIXER)
      else $error("no mixer preset");
   a_one_channel: assert property (RX_ENABLE && !RX_DUAL_CHANNEL |=>
      AM_CH_EN != PM_CH_EN && FRAMING_USES_PM == PM_CH_EN) else $error("bad channel");
   a_both_channels: assert property (RX_ENABLE && RX_DUAL_CHANNEL |=> AM_CH_EN && PM_CH_EN)
      else $error("channel off");
   a_mixer_single: assert property (SINGLE_ENDED |=> PM_MIXER_INTERNAL)
      else $error("mixer clock source");
   a_mask_start: assert property (TX_END |=> MASK_RX_ACTIVE [*8])
      else $error("mask timer idle");
   a_squelch_delay: assert property ($rose(SQUELCH_ACTIVE) |-> $past(TX_END, 379))
      else $error("squelch start time");
   a_squelch_mask: assert property (SQUELCH_ACTIVE |-> MASK_RX_ACTIVE)
      else $error("squelch outside mask");
endmodule
bind rxc_receiver_config_regs rx_config_checker chk_u (.*);
`default_nettype wire

/* bench/rx_receiver_config_regs_tb.sv */
// self-checking bench for the receiver configuration registers
`default_nettype none
module rx_receiver_config_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK = 0, RESET = 1, SET_DEFAULT = 0, REG_WR = 0, RX_ENABLE = 1, TX_END = 0;
   logic RX_DUAL_CHANNEL = 0, MANUAL_CH_SELECT = 0, AUTO_FRAMING_PM = 0, SINGLE_ENDED = 0;
   logic VERY_HIGH_BITRATE = 0, PEER_ACTIVE_PRESET = 0, CARRIER_CLK_IN = 0;
   logic [5:0] REG_ADDR = 0;
   logic [7:0] REG_WDATA = 0, MASK_RX_STEPS = 0, REG_RDATA;
   logic AM_CH_EN, PM_CH_EN, FRAMING_USES_PM, AM_DEMOD_MIXER, RECEIVER_LOW_POWER, AGC_ENABLE;
   logic LOWFREQ_INPUT_SPLIT, LOWFREQ_INPUT_ENABLE, AGC_FULL_PERIOD, AGC_ALG_RESET;
   logic SQUELCH_ACTIVE, MASK_RX_ACTIVE, PM_MIXER_INTERNAL, STAGE_CLIP, FORCED_PEER_GAIN;
   logic [2:0] LOWPASS_CODE, ZERO_SETTING, AM_STAGE1_GAIN, PM_STAGE1_GAIN;
   int fails = 0, cmp_count = 0, sq, mk;
   logic [21:0] rows [13] = '{22'h0a_8080, 22'h0a_7f7f, 22'h0b_e5e5, 22'h0b_0604, 22'h0b_1a18,
      22'h0c_1d1d, 22'h0c_3a3a, 22'h0c_5757, 22'h0c_7070, 22'h0c_8d8d, 22'h0c_aaaa, 22'h0c_c6c6,
      22'h0c_e3e3};
   logic [15:0] dflt [3] = '{16'h0000, 16'h1a18, 16'hd8d8};
   rxc_receiver_config_regs dut_u (.*);
   always #25 CLK = ~CLK;
   // slow carrier so the shortest mask window outlasts the squelch delay
   always
   begin
      repeat (2) @(negedge CLK);
      CARRIER_CLK_IN = ~CARRIER_CLK_IN;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("FAIL %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      if (fails == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WR = 1;
      @(negedge CLK);
      REG_WR = 0;
   endtask
   task automatic rd(input logic [5:0] a);
      REG_ADDR = a;
      repeat (3) @(negedge CLK);
   endtask
   function automatic logic [7:0] obs(input logic [5:0] a);
      if (a == 6'h0a)
         return {PM_CH_EN, AM_DEMOD_MIXER, LOWPASS_CODE, ZERO_SETTING};
      if (a == 6'h0b)
         return {RECEIVER_LOW_POWER, LOWFREQ_INPUT_SPLIT, LOWFREQ_INPUT_ENABLE, AGC_ENABLE,
            AGC_FULL_PERIOD, AGC_ALG_RESET, 1'b0, PM_MIXER_INTERNAL};
      return {AM_STAGE1_GAIN, PM_STAGE1_GAIN, STAGE_CLIP, FORCED_PEER_GAIN};
   endfunction
   task automatic defaults;
      for (int k = 0; k < 3; k++)
      begin
         rd(6'h0a + 6'(k));
         chk(REG_RDATA, dflt[k][15:8]);
         chk(obs(6'h0a + 6'(k)), dflt[k][7:0]);
      end
   endtask
   task automatic burst(input logic [7:0] steps);
      MASK_RX_STEPS = steps;
      TX_END = 1;
      @(negedge CLK);
      TX_END = 0;
      sq = 0;
      for (mk = 1; mk < 3000; mk++)
      begin
         @(negedge CLK);
         if (SQUELCH_ACTIVE === 1'b1 && sq == 0)
            sq = mk;
         if (MASK_RX_ACTIVE !== 1'b1)
            break;
      end
      if (mk == 3000)
      begin
         fails++;
         print_verdict;
      end
   endtask
   initial
   begin
      repeat (12) @(negedge CLK);
      RESET = 0;
      defaults;
      foreach (rows[i])
      begin
         wr(rows[i][21:16], rows[i][15:8]);
         rd(rows[i][21:16]);
         chk(REG_RDATA, rows[i][15:8]);
         chk(obs(rows[i][21:16]), rows[i][7:0]);
      end
      wr(6'h0d, 8'h5a);
      rd(6'h0d);
      chk(REG_RDATA, 8'h00);
      rd(6'h0c);
      chk(REG_RDATA, 8'he3);
      SET_DEFAULT = 1;
      wr(6'h0c, 8'h00);
      SET_DEFAULT = 0;
      defaults;
      RX_DUAL_CHANNEL = 1;
      MANUAL_CH_SELECT = 1;
      wr(6'h0a, 8'h80);
      rd(6'h0a);
      chk({5'h0, AM_CH_EN, PM_CH_EN, FRAMING_USES_PM}, 8'h07);
      MANUAL_CH_SELECT = 0;
      rd(6'h0a);
      chk({5'h0, AM_CH_EN, PM_CH_EN, FRAMING_USES_PM}, 8'h06);
      AUTO_FRAMING_PM = 1;
      rd(6'h0a);
      chk({5'h0, AM_CH_EN, PM_CH_EN, FRAMING_USES_PM}, 8'h07);
      AUTO_FRAMING_PM = 0;
      RX_DUAL_CHANNEL = 0;
      VERY_HIGH_BITRATE = 1;
      PEER_ACTIVE_PRESET = 1;
      SINGLE_ENDED = 1;
      rd(6'h0a);
      chk(REG_RDATA, 8'hc0);
      rd(6'h0c);
      chk(REG_RDATA, 8'hdb);
      chk({7'h0, PM_MIXER_INTERNAL}, 8'h01);
      wr(6'h0c, 8'hda);
      RX_ENABLE = 0;
      rd(6'h0c);
      chk(obs(6'h0c), 8'hda);
      chk({6'h0, AM_CH_EN, PM_CH_EN}, 8'h00);
      RX_ENABLE = 1;
      burst(8'h00);
      chk({7'h0, sq == 378}, 8'h01);
      chk({7'h0, mk > 1010 && mk < 1040}, 8'h01);
      wr(6'h0b, 8'h18);
      burst(8'h05);
      chk({7'h0, sq == 0}, 8'h01);
      chk({7'h0, mk > 1266 && mk < 1296}, 8'h01);
      RESET = 1;
      VERY_HIGH_BITRATE = 0;
      PEER_ACTIVE_PRESET = 0;
      SINGLE_ENDED = 0;
      repeat (2) @(negedge CLK);
      chk(obs(6'h0b), 8'h00);
      RESET = 0;
      defaults;
      print_verdict;
   end
endmodule
`default_nettype wire
